/* File: ead_pkg.sv */
/*
 * constants of the external area decoder: register offsets, field positions,
 * reset values, width codes, memory-type codes and address decode fields.
 * assumes nothing of its surroundings; compiled before every other file.
 */
package ead_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// register offsets on the plain register port
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_WIDTH = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;

	// control register fields
	localparam int CTRL_A6_CARD_BIT = 0;
	localparam int CTRL_A5_CARD_BIT = 1;
	localparam int CTRL_TYPE_LSB = 2;
	localparam int CTRL_TYPE_MSB = 4;
	localparam int CTRL_A6_IO_BIT = 5;
	localparam logic [15:0] CTRL_WMASK = 16'h003f;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	// area width register: two bits per area n at bit 2n
	localparam logic [15:0] WIDTH_WMASK = 16'h3ff0;
	localparam logic [15:0] WIDTH_RST = 16'h3ff0;

	// status register fields
	localparam int ST_A0W_LSB = 0;
	localparam int ST_A0W_MSB = 1;
	localparam int ST_ENDIAN_BIT = 2;
	localparam int ST_RSV_HIT_BIT = 3;
	localparam int ST_AREA_LSB = 4;
	localparam int ST_AREA_MSB = 6;
	localparam int ST_STRAP_BAD_BIT = 7;

	// bus width codes
	localparam logic [1:0] WID_RSV = 2'h0;
	localparam logic [1:0] WID_8 = 2'h1;
	localparam logic [1:0] WID_16 = 2'h2;
	localparam logic [1:0] WID_32 = 2'h3;

	// access size codes from the core
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	// memory type codes for areas 2 and 3
	localparam logic [2:0] TP_NORMAL = 3'h0;
	localparam logic [2:0] TP_A3_SDRAM = 3'h2;
	localparam logic [2:0] TP_BOTH_SDRAM = 3'h3;
	localparam logic [2:0] TP_A3_DRAM = 3'h4;
	localparam logic [2:0] TP_BOTH_DRAM = 3'h5;

	// address decode
	localparam int AREA_MSB = 28;
	localparam int AREA_LSB = 26;
	localparam int TOP_LSB = 26;
	localparam logic [5:0] ONCHIP_TOP = 6'h3f;
	localparam logic [2:0] AREA_0 = 3'h0;
	localparam logic [2:0] AREA_1 = 3'h1;
	localparam logic [2:0] AREA_2 = 3'h2;
	localparam logic [2:0] AREA_3 = 3'h3;
	localparam logic [2:0] AREA_5 = 3'h5;
	localparam logic [2:0] AREA_6 = 3'h6;
	localparam logic [2:0] AREA_7 = 3'h7;
	localparam int CARD_HALF_BIT = 25;

	// strap capture waits for the synchroniser to fill: the second
	// stage still holds its reset zero at the second edge after release
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

/* File: ead_sync.sv */
/*
 * two-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level such as a strap or card status pin.
 */
`timescale 1ns/1ps
`default_nettype none

module ead_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	generate
		if (W < 1) begin : g_chk
			$error("ead_sync width must be at least one");
		end
	endgenerate

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage is read only by the second
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

`default_nettype wire

/* File: ead_decoder.sv */
/*
 * external area decoder: sorts each physical address into areas 0..7,
 * drives the chip selects, card enables and dram/sdram strobes of the
 * addressed area, and reports the bus width that the access must use.
 * assumes the core holds acc_valid_i with a stable address for the whole
 * access; outputs follow the request one clock later.
 */
// Behaviour
// [RQ1] area from address bits 28..26, codes 0..6
// [RQ2] ignore bits 31..29, areas repeat as shadows
// [RQ3] assert only the accessed area's select
// [RQ4] dram/sdram areas also drive strobes and masks
// [RQ5] card access: enable-1 plus enable-2 for bytes; the code drives enable-2 only when lane 1 carries data, as on word accesses
// [RQ6] area 0 width from straps at reset
// [RQ7] areas 2..6 width from width register
// [RQ8] software sets area 2 word for dram
// [RQ9] software sets card areas byte or word
// [RQ10] port function needs byte or word widths
// [RQ11] sdram areas always use 32-bit bus
// [RQ12] area 3 dram 16/32, both dram 16
// [RQ13] top 64 MB is on-chip space, shadows reserved
// [RQ14] software never touches reserved space
// [RQ15] area 5 memory card only, area 6 both
// [RQ16] io16 sizing only in little endian
// [RQ17] software uses top bits 101 for untranslated
// [RQ18] card space only when select bit set
// [RQ19] no select for area 1 or area 7
`timescale 1ns/1ps
`default_nettype none

module ead_decoder #(
	parameter int ADDR_W = ead_pkg::ADDR_W,
	parameter int DATA_W = ead_pkg::DATA_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic acc_write_i,
	input wire logic [1:0] acc_size_i,
	input wire logic width_strap_hi_i,
	input wire logic width_strap_lo_i,
	input wire logic endian_strap_i,
	input wire logic card_io16_i,
	output logic area0_select_n_o,
	output logic [4:0] area_select_n_o,
	output logic card_a_enable_low_n_o,
	output logic card_a_enable_high_n_o,
	output logic card_b_enable_low_n_o,
	output logic card_b_enable_high_n_o,
	output logic card_io_read_n_o,
	output logic card_io_write_n_o,
	output logic write_direction_o,
	output logic row_strobe_n_o,
	output logic col_strobe_n_o,
	output logic [3:0] data_mask_o,
	output logic [2:0] acc_area_o,
	output logic [1:0] acc_width_o,
	output logic onchip_io_o,
	output logic reserved_hit_o
);

	generate
		if (DATA_W < 16 || ADDR_W < 4) begin : g_chk
			$error("ead_decoder needs 16-bit data and 4-bit register address");
		end
	endgenerate

	// pins from outside pass the synchroniser first
	logic [3:0] pins_s;

	ead_sync #(
		.W(4)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.async_i({card_io16_i, endian_strap_i, width_strap_hi_i, width_strap_lo_i}),
		.sync_o(pins_s)
	);

	logic io16_s;
	assign io16_s = pins_s[3];

	// register file and strap capture state
	logic [15:0] ctrl_q, ctrl_d;
	logic [15:0] width_q, width_d;
	logic [1:0] a0w_q, a0w_d;
	logic endian_q, endian_d;
	logic strap_bad_q, strap_bad_d;
	logic [1:0] settle_q, settle_d;
	logic rsv_hit_q, rsv_hit_d;
	logic [2:0] last_area_q, last_area_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;

	// decode results
	logic [2:0] code;
	logic onchip;
	logic reserved;
	logic hit;
	logic [2:0] tp;
	logic dram2, dram3, sdram2, sdram3;
	logic card5, card6, card_io;
	logic dram_acc;
	logic [1:0] width;
	logic [3:0] lanes;
	logic [4:0] sel_n;
	logic little;

	assign little = endian_q;

	always_comb begin
		code = acc_addr_i[ead_pkg::AREA_MSB:ead_pkg::AREA_LSB]; // RQ1 RQ2
		onchip = acc_addr_i[31:ead_pkg::TOP_LSB] == ead_pkg::ONCHIP_TOP; // RQ13
		reserved = code == ead_pkg::AREA_7 && !onchip; // RQ13
		hit = acc_valid_i && !onchip && code != ead_pkg::AREA_7 && code != ead_pkg::AREA_1; // RQ19
		tp = ctrl_q[ead_pkg::CTRL_TYPE_MSB:ead_pkg::CTRL_TYPE_LSB];
		dram2 = tp == ead_pkg::TP_BOTH_DRAM;
		dram3 = tp == ead_pkg::TP_A3_DRAM || tp == ead_pkg::TP_BOTH_DRAM;
		sdram2 = tp == ead_pkg::TP_BOTH_SDRAM;
		sdram3 = tp == ead_pkg::TP_A3_SDRAM || tp == ead_pkg::TP_BOTH_SDRAM;
		// card space is the lower half of area 5 and 6 only
		card5 = hit && code == ead_pkg::AREA_5 && !acc_addr_i[ead_pkg::CARD_HALF_BIT]
			&& ctrl_q[ead_pkg::CTRL_A5_CARD_BIT]; // RQ18
		card6 = hit && code == ead_pkg::AREA_6 && !acc_addr_i[ead_pkg::CARD_HALF_BIT]
			&& ctrl_q[ead_pkg::CTRL_A6_CARD_BIT]; // RQ18
		// io cycles exist on area 6 only; area 5 stays a memory card
		card_io = card6 && ctrl_q[ead_pkg::CTRL_A6_IO_BIT]; // RQ15
		dram_acc = hit && ((code == ead_pkg::AREA_2 && (dram2 || sdram2))
			|| (code == ead_pkg::AREA_3 && (dram3 || sdram3))); // RQ4
	end

	// bus width of the addressed area
	always_comb begin
		width = ead_pkg::WID_RSV;
		if (onchip || code == ead_pkg::AREA_1) begin
			width = ead_pkg::WID_32;
		end else if (code == ead_pkg::AREA_0) begin
			width = a0w_q; // RQ6
		end else if (code != ead_pkg::AREA_7) begin
			width = width_q[2*code +: 2]; // RQ7
			if ((code == ead_pkg::AREA_2 && sdram2) || (code == ead_pkg::AREA_3 && sdram3)) begin
				width = ead_pkg::WID_32; // RQ11
			end else if (code == ead_pkg::AREA_3 && dram2) begin
				width = ead_pkg::WID_16; // RQ12
			end else if (code == ead_pkg::AREA_3 && dram3 && width != ead_pkg::WID_32) begin
				width = ead_pkg::WID_16; // RQ12
			end else if (code == ead_pkg::AREA_2 && dram2) begin
				width = ead_pkg::WID_16;
			end
			// narrow 8-bit card io port seen only in little endian
			if (card_io && little && !io16_s && width == ead_pkg::WID_16) begin
				width = ead_pkg::WID_8; // RQ16
			end
		end
	end

	// byte lanes that carry data in this bus cycle
	always_comb begin
		lanes = 4'h0;
		unique case (width)
			ead_pkg::WID_32: begin
				if (acc_size_i == ead_pkg::SIZE_BYTE) begin
					lanes[little ? acc_addr_i[1:0] : ~acc_addr_i[1:0]] = 1'b1;
				end else if (acc_size_i == ead_pkg::SIZE_WORD) begin
					lanes = (acc_addr_i[1] ^ !little) ? 4'hc : 4'h3;
				end else begin
					lanes = 4'hf;
				end
			end
			ead_pkg::WID_16: begin
				if (acc_size_i == ead_pkg::SIZE_BYTE) begin
					lanes = (acc_addr_i[0] ^ !little) ? 4'h2 : 4'h1;
				end else begin
					lanes = 4'h3;
				end
			end
			ead_pkg::WID_8: begin
				lanes = 4'h1;
			end
			ead_pkg::WID_RSV: begin
				lanes = 4'h0;
			end
		endcase
	end

	// one select per external area 2..6
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_sel
			localparam logic [2:0] AREA_N = 3'(g + 2);
			// card accesses use the card enables in place of the select
			assign sel_n[g] = !(hit && code == AREA_N
				&& !(AREA_N == ead_pkg::AREA_5 && card5)
				&& !(AREA_N == ead_pkg::AREA_6 && card6)); // RQ3
		end
	endgenerate

	// output registers
	logic a0sel_n_q, a0sel_n_d;
	logic [4:0] sel_n_q, sel_n_d;
	logic cea_lo_n_q, cea_lo_n_d, cea_hi_n_q, cea_hi_n_d;
	logic ceb_lo_n_q, ceb_lo_n_d, ceb_hi_n_q, ceb_hi_n_d;
	logic iord_n_q, iord_n_d, iowr_n_q, iowr_n_d;
	logic wdir_q, wdir_d;
	logic ras_n_q, ras_n_d, cas_n_q, cas_n_d;
	logic [3:0] dqm_q, dqm_d;
	logic [2:0] area_q, area_d;
	logic [1:0] wid_q, wid_d;
	logic onchip_q, onchip_d;
	logic rsv_q, rsv_d;

	always_comb begin
		a0sel_n_d = !(hit && code == ead_pkg::AREA_0); // RQ3
		sel_n_d = sel_n;
		cea_lo_n_d = !card5; // RQ5
		cea_hi_n_d = !(card5 && lanes[1]); // RQ5
		ceb_lo_n_d = !card6; // RQ5
		ceb_hi_n_d = !(card6 && lanes[1]); // RQ5
		iord_n_d = !(card_io && !acc_write_i); // RQ15
		iowr_n_d = !(card_io && acc_write_i); // RQ15
		wdir_d = (dram_acc || card5 || card6) && acc_write_i; // RQ4
		ras_n_d = !dram_acc; // RQ4
		cas_n_d = !dram_acc; // RQ4
		// masks stay high outside dram cycles so idle lanes are masked
		dqm_d = dram_acc ? ~lanes : 4'hf; // RQ4
		area_d = acc_valid_i ? code : area_q;
		wid_d = acc_valid_i ? width : wid_q;
		onchip_d = acc_valid_i && onchip; // RQ13
		rsv_d = acc_valid_i && reserved; // RQ13
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a0sel_n_q <= 1'b1;
			sel_n_q <= 5'h1f;
			cea_lo_n_q <= 1'b1;
			cea_hi_n_q <= 1'b1;
			ceb_lo_n_q <= 1'b1;
			ceb_hi_n_q <= 1'b1;
			iord_n_q <= 1'b1;
			iowr_n_q <= 1'b1;
			wdir_q <= 1'b0;
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			dqm_q <= 4'hf;
			area_q <= 3'h0;
			wid_q <= 2'h0;
			onchip_q <= 1'b0;
			rsv_q <= 1'b0;
		end else begin
			a0sel_n_q <= a0sel_n_d;
			sel_n_q <= sel_n_d;
			cea_lo_n_q <= cea_lo_n_d;
			cea_hi_n_q <= cea_hi_n_d;
			ceb_lo_n_q <= ceb_lo_n_d;
			ceb_hi_n_q <= ceb_hi_n_d;
			iord_n_q <= iord_n_d;
			iowr_n_q <= iowr_n_d;
			wdir_q <= wdir_d;
			ras_n_q <= ras_n_d;
			cas_n_q <= cas_n_d;
			dqm_q <= dqm_d;
			area_q <= area_d;
			wid_q <= wid_d;
			onchip_q <= onchip_d;
			rsv_q <= rsv_d;
		end
	end

	// register port and strap capture
	always_comb begin
		ctrl_d = ctrl_q;
		width_d = width_q;
		a0w_d = a0w_q;
		endian_d = endian_q;
		strap_bad_d = strap_bad_q;
		settle_d = settle_q;
		rsv_hit_d = rsv_hit_q;
		last_area_d = acc_valid_i ? code : last_area_q;
		rdata_d = '0;
		// straps are caught once, after the synchroniser has filled
		if (settle_q != ead_pkg::STRAP_SETTLE) begin
			settle_d = settle_q + 2'h1;
			if (settle_q + 2'h1 == ead_pkg::STRAP_SETTLE) begin
				a0w_d = {pins_s[1], pins_s[0]}; // RQ6
				endian_d = pins_s[2];
				strap_bad_d = {pins_s[1], pins_s[0]} == ead_pkg::WID_RSV;
			end
		end
		if (reg_wr_i) begin
			unique case (reg_addr_i[3:0])
				ead_pkg::OFF_CTRL: ctrl_d = reg_wdata_i[15:0] & ead_pkg::CTRL_WMASK;
				ead_pkg::OFF_WIDTH: width_d = reg_wdata_i[15:0] & ead_pkg::WIDTH_WMASK; // RQ7
				ead_pkg::OFF_STATUS: begin
					if (reg_wdata_i[ead_pkg::ST_RSV_HIT_BIT]) begin
						rsv_hit_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// a new reserved hit wins over a clear in the same cycle
		if (acc_valid_i && reserved) begin
			rsv_hit_d = 1'b1; // RQ13
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i[3:0])
				ead_pkg::OFF_CTRL: rdata_d[15:0] = ctrl_q;
				ead_pkg::OFF_WIDTH: rdata_d[15:0] = width_q;
				ead_pkg::OFF_STATUS: begin
					rdata_d[ead_pkg::ST_A0W_MSB:ead_pkg::ST_A0W_LSB] = a0w_q;
					rdata_d[ead_pkg::ST_ENDIAN_BIT] = endian_q;
					rdata_d[ead_pkg::ST_RSV_HIT_BIT] = rsv_hit_q;
					rdata_d[ead_pkg::ST_AREA_MSB:ead_pkg::ST_AREA_LSB] = last_area_q;
					rdata_d[ead_pkg::ST_STRAP_BAD_BIT] = strap_bad_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= ead_pkg::CTRL_RST;
			width_q <= ead_pkg::WIDTH_RST;
			a0w_q <= ead_pkg::WID_RSV;
			endian_q <= 1'b0;
			strap_bad_q <= 1'b0;
			settle_q <= 2'h0;
			rsv_hit_q <= 1'b0;
			last_area_q <= 3'h0;
			rdata_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			width_q <= width_d;
			a0w_q <= a0w_d;
			endian_q <= endian_d;
			strap_bad_q <= strap_bad_d;
			settle_q <= settle_d;
			rsv_hit_q <= rsv_hit_d;
			last_area_q <= last_area_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign area0_select_n_o = a0sel_n_q;
	assign area_select_n_o = sel_n_q;
	assign card_a_enable_low_n_o = cea_lo_n_q;
	assign card_a_enable_high_n_o = cea_hi_n_q;
	assign card_b_enable_low_n_o = ceb_lo_n_q;
	assign card_b_enable_high_n_o = ceb_hi_n_q;
	assign card_io_read_n_o = iord_n_q;
	assign card_io_write_n_o = iowr_n_q;
	assign write_direction_o = wdir_q;
	assign row_strobe_n_o = ras_n_q;
	assign col_strobe_n_o = cas_n_q;
	assign data_mask_o = dqm_q;
	assign acc_area_o = area_q;
	assign acc_width_o = wid_q;
	assign onchip_io_o = onchip_q;
	assign reserved_hit_o = rsv_q;

endmodule

`default_nettype wire

/* File: ead_decoder_monitor.sv */
/*
 * concurrent checks on the area decoder's ports: selects, strobes,
 * card enables and space flags.
 * assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module ead_decoder_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic area0_select_n_o,
	input wire logic [4:0] area_select_n_o,
	input wire logic card_a_enable_low_n_o,
	input wire logic card_a_enable_high_n_o,
	input wire logic card_b_enable_low_n_o,
	input wire logic card_b_enable_high_n_o,
	input wire logic row_strobe_n_o,
	input wire logic col_strobe_n_o,
	input wire logic [2:0] acc_area_o,
	input wire logic [1:0] acc_width_o,
	input wire logic onchip_io_o,
	input wire logic reserved_hit_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	// top three address bits are left out on purpose: shadows hit too
	sequence s_hit(logic [2:0] c);
		acc_valid_i && acc_addr_i[28:26] == c;
	endsequence

	a_area0_sel: assert property (s_hit(3'h0) |=> !area0_select_n_o && &area_select_n_o)
		else $error("area 0 select wrong");
	a_area4_sel: assert property (s_hit(3'h4) |=> area_select_n_o == 5'h1b && area0_select_n_o)
		else $error("area 4 select wrong");
	a_shadow_code: assert property (s_hit(3'h6) |=> acc_area_o == 3'h6)
		else $error("area code wrong");
	a_area1_quiet: assert property (s_hit(3'h1) |=> area0_select_n_o && &area_select_n_o
		&& acc_width_o == 2'h3)
		else $error("select during area 1");
	a_onchip_flag: assert property (acc_valid_i && &acc_addr_i[31:26] |=> onchip_io_o
		&& !reserved_hit_o && &area_select_n_o)
		else $error("on-chip access wrong");
	a_rsv_flag: assert property (s_hit(3'h7) ##0 !(&acc_addr_i[31:29]) |=> reserved_hit_o
		&& area0_select_n_o)
		else $error("reserved access wrong");
	a_idle_quiet: assert property (!acc_valid_i |=> area0_select_n_o && &area_select_n_o
		&& row_strobe_n_o)
		else $error("select without access");
	a_card_pair: assert property ((!card_a_enable_high_n_o |-> !card_a_enable_low_n_o)
		and (!card_b_enable_high_n_o |-> !card_b_enable_low_n_o))
		else $error("enable 2 without enable 1");
	a_strobe_area: assert property (!row_strobe_n_o |-> acc_area_o inside {3'h2, 3'h3}
		&& row_strobe_n_o == col_strobe_n_o)
		else $error("strobe outside dram areas");
endmodule

bind ead_decoder ead_decoder_monitor u_mon (.sys_clk_i, .rst_b_i, .acc_valid_i, .acc_addr_i,
	.area0_select_n_o, .area_select_n_o, .card_a_enable_low_n_o, .card_a_enable_high_n_o,
	.card_b_enable_low_n_o, .card_b_enable_high_n_o, .row_strobe_n_o, .col_strobe_n_o,
	.acc_area_o, .acc_width_o, .onchip_io_o, .reserved_hit_o);

`default_nettype wire

/* File: ead_card_model.sv */
/*
 * far-side io card: reports its port width on the 16-bit io line.
 * assumes the bench picks the card's port width.
 */
`timescale 1ns/1ps
`default_nettype none

module ead_card_model (
	input wire logic wide_i,
	output logic io16_o
);
	// a static card level; the decoder syncs it with a lag
	assign io16_o = wide_i;
endmodule

`default_nettype wire

/* File: ead_decoder_tb.sv */
/*
 * self-checking bench of the area decoder: map, widths, dram, cards.
 * assumes the bound monitor and the io card model.
 */
`timescale 1ns/1ps
`default_nettype none

module ead_decoder_tb;
	logic sys_clk_i, rst_b_i, reg_wr_i, reg_rd_i, acc_valid_i, acc_write_i, wide;
	logic [3:0] reg_addr_i, data_mask_o;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic [31:0] acc_addr_i;
	logic [1:0] acc_size_i, acc_width_o;
	logic card_io16_i, area0_select_n_o, card_a_enable_low_n_o, card_a_enable_high_n_o;
	logic card_b_enable_low_n_o, card_b_enable_high_n_o, card_io_read_n_o, card_io_write_n_o;
	logic write_direction_o, row_strobe_n_o, col_strobe_n_o, onchip_io_o, reserved_hit_o;
	logic [4:0] area_select_n_o;
	logic [2:0] acc_area_o;
	int error_cnt, checked;
	logic strap_hi, strap_lo, endian;

	ead_decoder dut (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .acc_valid_i, .acc_addr_i, .acc_write_i, .acc_size_i,
		.width_strap_hi_i(strap_hi), .width_strap_lo_i(strap_lo), .endian_strap_i(endian),
		.card_io16_i, .area0_select_n_o, .area_select_n_o, .card_a_enable_low_n_o,
		.card_a_enable_high_n_o, .card_b_enable_low_n_o, .card_b_enable_high_n_o,
		.card_io_read_n_o, .card_io_write_n_o, .write_direction_o, .row_strobe_n_o,
		.col_strobe_n_o, .data_mask_o, .acc_area_o, .acc_width_o, .onchip_io_o, .reserved_hit_o);
	ead_card_model u_card (.wide_i(wide), .io16_o(card_io16_i));

	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		cmp(n, e, reg_rdata_o);
	endtask

	task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s);
		@(posedge sys_clk_i);
		acc_valid_i <= 1'b1;
		acc_addr_i <= a;
		acc_write_i <= w;
		acc_size_i <= s;
		@(posedge sys_clk_i);
		acc_valid_i <= 1'b0;
		@(negedge sys_clk_i);
	endtask

	task automatic t_map();
		logic [4:0] es;
		for (int c = 0; c < 7; c++) begin
			// top bits equal to c give a different shadow each pass
			acc({c[2:0], c[2:0], 26'h0}, 1'b0, ead_pkg::SIZE_LONG);
			es = (c >= 2) ? ~(5'h01 << (c - 2)) : 5'h1f;
			cmp("area", 16'(c[2:0]), 16'(acc_area_o));
			cmp("sel0", 16'(c != 0), 16'(area0_select_n_o));
			cmp("sel", 16'(es), 16'(area_select_n_o));
		end
		// untranslated view of area 1 lands on its shadow
		acc(32'ha4000000, 1'b0, ead_pkg::SIZE_LONG);
		cmp("sel", 16'h3f, 16'({area0_select_n_o, area_select_n_o}));
		acc(32'hfc000010, 1'b1, ead_pkg::SIZE_LONG);
		cmp("onchip", 16'h1, 16'(onchip_io_o));
		cmp("sel", 16'h3f, 16'({area0_select_n_o, area_select_n_o}));
		acc(32'h5c000000, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("rsv", 16'h1, 16'(reserved_hit_o));
	endtask

	task automatic t_wid();
		rreg(ead_pkg::OFF_WIDTH, ead_pkg::WIDTH_RST, "wreg");
		rreg(ead_pkg::OFF_CTRL, ead_pkg::CTRL_RST, "ctrl");
		wreg(ead_pkg::OFF_WIDTH, 16'hffff);
		rreg(ead_pkg::OFF_WIDTH, 16'h3ff0, "wreg_ro");
		rreg(4'hc, 16'h0, "unmapped");
		// areas 2,3,5,6 word, area 4 byte
		wreg(ead_pkg::OFF_WIDTH, 16'h29a0);
		for (int c = 2; c < 7; c++) begin
			acc({3'h0, c[2:0], 26'h0}, 1'b0, ead_pkg::SIZE_BYTE);
			cmp("width", 16'((c == 4) ? ead_pkg::WID_8 : ead_pkg::WID_16), 16'(acc_width_o));
		end
		acc(32'h20000000, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("width0", 16'(ead_pkg::WID_16), 16'(acc_width_o));
		rreg(ead_pkg::OFF_STATUS, 16'h000e, "status");
	endtask

	task automatic t_dram();
		wreg(ead_pkg::OFF_CTRL, 16'(ead_pkg::TP_BOTH_DRAM) << ead_pkg::CTRL_TYPE_LSB);
		acc(32'h08000005, 1'b1, ead_pkg::SIZE_BYTE);
		cmp("strobes", 16'h0, 16'({row_strobe_n_o, col_strobe_n_o}));
		cmp("wdir", 16'h1, 16'(write_direction_o));
		cmp("mask", 16'hd, 16'(data_mask_o));
		cmp("width", 16'(ead_pkg::WID_16), 16'(acc_width_o));
		wreg(ead_pkg::OFF_WIDTH, 16'h29e0);
		acc(32'h0c000000, 1'b0, ead_pkg::SIZE_LONG);
		cmp("width", 16'(ead_pkg::WID_16), 16'(acc_width_o));
		wreg(ead_pkg::OFF_CTRL, 16'(ead_pkg::TP_A3_DRAM) << ead_pkg::CTRL_TYPE_LSB);
		acc(32'h0c000000, 1'b0, ead_pkg::SIZE_LONG);
		cmp("width", 16'(ead_pkg::WID_32), 16'(acc_width_o));
		wreg(ead_pkg::OFF_CTRL, 16'(ead_pkg::TP_A3_SDRAM) << ead_pkg::CTRL_TYPE_LSB);
		wreg(ead_pkg::OFF_WIDTH, 16'h29a0);
		acc(32'h0c000000, 1'b0, ead_pkg::SIZE_LONG);
		cmp("width", 16'(ead_pkg::WID_32), 16'(acc_width_o));
		acc(32'h08000000, 1'b0, ead_pkg::SIZE_LONG);
		cmp("mask", 16'hf, 16'(data_mask_o));
	endtask

	task automatic t_card();
		wreg(ead_pkg::OFF_CTRL, 16'h0023);
		acc(32'h14000000, 1'b0, ead_pkg::SIZE_WORD);
		cmp("card_a", 16'h0, 16'({card_a_enable_low_n_o, card_a_enable_high_n_o}));
		cmp("sel5", 16'h1, 16'(area_select_n_o[3]));
		cmp("io_rd", 16'h1, 16'(card_io_read_n_o));
		acc(32'h14000000, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("card_a", 16'h1, 16'({card_a_enable_low_n_o, card_a_enable_high_n_o}));
		acc(32'h16000000, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("sel5", 16'h0, 16'(area_select_n_o[3]));
		cmp("card_a", 16'h3, 16'({card_a_enable_low_n_o, card_a_enable_high_n_o}));
		acc(32'h18000002, 1'b1, ead_pkg::SIZE_WORD);
		cmp("card_b", 16'h0, 16'({card_b_enable_low_n_o, card_b_enable_high_n_o}));
		cmp("io_wr", 16'h0, 16'(card_io_write_n_o));
		cmp("width", 16'(ead_pkg::WID_16), 16'(acc_width_o));
		wide <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		acc(32'h18000002, 1'b1, ead_pkg::SIZE_WORD);
		cmp("width", 16'(ead_pkg::WID_8), 16'(acc_width_o));
		wide <= 1'b1;
		wreg(ead_pkg::OFF_CTRL, 16'h0);
	endtask

	task automatic t_strap();
		// second power-on: 8-bit area 0, big endian
		@(posedge sys_clk_i);
		rst_b_i <= 1'b0;
		strap_hi <= 1'b0;
		strap_lo <= 1'b1;
		endian <= 1'b0;
		wide <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		acc(32'h00000001, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("width0", 16'(ead_pkg::WID_8), 16'(acc_width_o));
		rreg(ead_pkg::OFF_STATUS, 16'h0001, "status");
		acc(32'h1c000000, 1'b0, ead_pkg::SIZE_BYTE);
		rreg(ead_pkg::OFF_STATUS, 16'h0079, "status_rsv");
		wreg(ead_pkg::OFF_STATUS, 16'h0008);
		rreg(ead_pkg::OFF_STATUS, 16'h0071, "status_clr");
		wreg(ead_pkg::OFF_WIDTH, 16'h29a0);
		wreg(ead_pkg::OFF_CTRL, 16'h0023);
		// narrow io card, but big endian keeps the word bus
		acc(32'h18000000, 1'b0, ead_pkg::SIZE_BYTE);
		cmp("width", 16'(ead_pkg::WID_16), 16'(acc_width_o));
		cmp("card_b", 16'h0, 16'({card_b_enable_low_n_o, card_b_enable_high_n_o}));
		cmp("io_rd", 16'h0, 16'(card_io_read_n_o));
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		error_cnt++;
		end_of_test();
	end

	initial begin
		{rst_b_i, reg_wr_i, reg_rd_i, acc_valid_i, acc_write_i} = 5'h0;
		{reg_addr_i, reg_wdata_i, acc_addr_i, acc_size_i} = '0;
		wide = 1'b1;
		strap_hi = 1'b1;
		strap_lo = 1'b0;
		endian = 1'b1;
		error_cnt = 0;
		checked = 0;
		repeat (12) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		// straps need a few edges to be captured
		repeat (4) @(posedge sys_clk_i);
		t_map();
		t_wid();
		t_dram();
		t_card();
		t_strap();
		end_of_test();
	end
endmodule

`default_nettype wire
